// ---- tgst_top.sv ----
// tgst_top: transmit guard, over-temperature lockout and self-test reporting
// assumes ptt is debounced and test_req is a one-cycle pulse, both on sys_clk
`timescale 1ns/1ps
`default_nettype none
module tgst_top #(
   parameter longint unsigned TX_LIMIT_CYC    = tgst_pkg::TX_LIMIT_CYC,
   parameter longint unsigned DKEY_GAP_CYC    = tgst_pkg::DKEY_GAP_CYC,
   parameter longint unsigned TEMP_PERIOD_CYC = tgst_pkg::TEMP_PERIOD_CYC,
   parameter longint unsigned BEEP_CYC        = tgst_pkg::BEEP_CYC,
   parameter longint unsigned TEST_STEP_CYC   = tgst_pkg::TEST_STEP_CYC,
   parameter longint unsigned TONE_HALF_CYC   = tgst_pkg::TONE_HALF_CYC
) (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                arst_n,
   // operator and control unit
   input  wire logic                ptt,
   input  wire logic                test_req,
   // measurements
   input  wire logic [7:0]          tx_temp_c,
   input  wire logic [10:0]         fault_in,
   // transmitter
   output logic                     tx_key,
   output logic                     rx_enable,
   output logic                     sidetone_en,
   output logic                     audio_tone,
   // display
   output logic                     test_busy,
   output logic [7:0]               brightness,
   output tgst_pkg::tgst_disp_t     active_disp,
   output logic                     self_test_fail_indicator,
   output logic [7:0]               preset_code,
   output logic                     preset_show
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   tgst_pkg::tgst_key_t key_st;
   tgst_pkg::tgst_key_t next_key_st;
   logic [35:0] tx_cnt;
   logic [35:0] next_tx_cnt;
   logic [31:0] gap_cnt;
   logic [31:0] next_gap_cnt;
   logic [31:0] samp_cnt;
   logic [31:0] next_samp_cnt;
   logic        hot;
   logic        next_hot;
   logic        ptt_q;
   logic        timed_out;
   logic        next_timed_out;
   logic        temp_trip;
   logic        next_temp_trip;
   logic        next_tx_key;
   logic        next_sidetone_en;
   logic        beep_start;
   logic        next_beep_start;
   logic        ptt_rise;
   logic        ptt_fall;
   logic        hot_now;

   tgst_beep_if bif ();

   // ----------------------------------------
   // key guard
   // ----------------------------------------
   assign ptt_rise = ptt & ~ptt_q;
   assign ptt_fall = ~ptt & ptt_q;
   assign hot_now  = (tx_temp_c > tgst_pkg::TEMP_LIMIT_C);

   always_comb begin
      next_key_st     = key_st;
      next_tx_cnt     = tx_cnt;
      next_gap_cnt    = gap_cnt;
      next_samp_cnt   = samp_cnt;
      next_hot        = hot;
      next_timed_out  = 1'b0;
      next_temp_trip  = 1'b0;
      next_beep_start = 1'b0;
      if (samp_cnt >= 32'(TEMP_PERIOD_CYC - 1)) begin
         next_samp_cnt = 32'h0;
         next_hot      = hot_now;
      end else begin
         next_samp_cnt = samp_cnt + 32'h1;
      end
      unique case (key_st)
         tgst_pkg::TGST_IDLE: begin
            next_tx_cnt = 36'h0;
            if (ptt_rise) begin
               next_key_st  = hot ? tgst_pkg::TGST_HOT_GAP : tgst_pkg::TGST_TX;
               next_gap_cnt = 32'h0;
            end
         end
         tgst_pkg::TGST_TX, tgst_pkg::TGST_HOT_TX: begin
            next_tx_cnt = tx_cnt + 36'h1;
            if (!ptt) begin
               next_key_st = tgst_pkg::TGST_IDLE;
            end else if (tx_cnt >= 36'(TX_LIMIT_CYC - 1)) begin
               next_key_st    = tgst_pkg::TGST_WAIT_REL;
               next_timed_out = 1'b1;
            // hot event in normal transmit ends it
            end else if (key_st == tgst_pkg::TGST_TX && hot) begin
               next_key_st    = tgst_pkg::TGST_WAIT_REL;
               next_temp_trip = 1'b1;
            end
         end
         tgst_pkg::TGST_WAIT_REL: begin
            // beeps on release after timeout, hot shutdown or an expired hot lockout gap
            if (!ptt) begin
               next_key_st     = tgst_pkg::TGST_IDLE;
               next_beep_start = 1'b1;
            end
         end
         tgst_pkg::TGST_HOT_GAP: begin
            // second quick press held overrides lockout
            next_gap_cnt = gap_cnt + 32'h1;
            if (!hot) begin
               next_key_st = ptt ? tgst_pkg::TGST_TX : tgst_pkg::TGST_IDLE;
            end else if (gap_cnt >= 32'(DKEY_GAP_CYC - 1)) begin
               next_key_st = ptt ? tgst_pkg::TGST_WAIT_REL : tgst_pkg::TGST_IDLE;
            end else if (ptt_rise) begin
               next_key_st = tgst_pkg::TGST_HOT_TX;
               next_tx_cnt = 36'h0;
            end
         end
      endcase
      next_tx_key      = (next_key_st == tgst_pkg::TGST_TX) ||
                         (next_key_st == tgst_pkg::TGST_HOT_TX);
      next_sidetone_en = next_tx_key;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         key_st      <= tgst_pkg::TGST_IDLE;
         tx_cnt      <= 36'h0;
         gap_cnt     <= 32'h0;
         samp_cnt    <= 32'h0;
         hot         <= 1'b0;
         ptt_q       <= 1'b0;
         timed_out   <= 1'b0;
         temp_trip   <= 1'b0;
         tx_key      <= 1'b0;
         rx_enable   <= 1'b1;
         sidetone_en <= 1'b0;
         beep_start  <= 1'b0;
      end else begin
         key_st      <= next_key_st;
         tx_cnt      <= next_tx_cnt;
         gap_cnt     <= next_gap_cnt;
         samp_cnt    <= next_samp_cnt;
         hot         <= next_hot;
         ptt_q       <= ptt;
         timed_out   <= next_timed_out;
         temp_trip   <= next_temp_trip;
         tx_key      <= next_tx_key;
         rx_enable   <= ~next_tx_key;
         sidetone_en <= next_sidetone_en;
         beep_start  <= next_beep_start;
      end
   end

   // ----------------------------------------
   // fault record and self-test
   // ----------------------------------------
   logic [10:0] fault_seen;
   logic [10:0] next_fault_seen;
   logic [31:0] step_cnt;
   logic [31:0] next_step_cnt;
   logic [7:0]  step;
   logic [7:0]  next_step;
   logic        next_test_busy;
   logic [7:0]  next_brightness;
   tgst_pkg::tgst_disp_t next_active_disp;
   logic        next_fail_ind;
   logic [7:0]  next_preset_code;
   logic        next_preset_show;
   logic [7:0]  lowest_code;
   logic        tone_kick;

   always_comb begin
      lowest_code = tgst_pkg::CODE_NONE;
      for (int i = tgst_pkg::NFAULT - 1; i >= 0; i--) begin
         if (fault_seen[i]) begin
            lowest_code = tgst_pkg::FAULT_BCD[i];
         end
      end
   end

   always_comb begin
      next_fault_seen = fault_seen | fault_in;
      next_fault_seen[tgst_pkg::IDX_TEMP] = fault_seen[tgst_pkg::IDX_TEMP] |
                                            fault_in[tgst_pkg::IDX_TEMP] | temp_trip;
      next_fault_seen[tgst_pkg::IDX_TIMEOUT] = fault_seen[tgst_pkg::IDX_TIMEOUT] |
                                               fault_in[tgst_pkg::IDX_TIMEOUT] | timed_out;
      next_step_cnt    = step_cnt;
      next_step        = step;
      next_test_busy   = test_busy;
      next_brightness  = brightness;
      next_active_disp = active_disp;
      next_fail_ind    = self_test_fail_indicator;
      next_preset_code = preset_code;
      next_preset_show = preset_show;
      tone_kick        = 1'b0;
      if (!test_busy) begin
         if (test_req) begin
            next_test_busy   = 1'b1;
            next_step        = 8'h00;
            next_step_cnt    = 32'h0;
            next_brightness  = 8'h00;
            next_active_disp = tgst_pkg::TGST_DISP_BLANK;
            next_fail_ind    = 1'b0;
            next_preset_show = 1'b0;
            tone_kick        = 1'b1;
         end
      end else if (step_cnt >= 32'(TEST_STEP_CYC - 1)) begin
         next_step_cnt   = 32'h0;
         next_step       = step + 8'h01;
         // brightness ramps 0x00 to 0xF0 in 16 steps, repeatedly
         next_brightness = {step[3:0], 4'h0};
         tone_kick       = (step[3:0] == 4'h0) && (step[5:4] != tgst_pkg::TEST_TONE_MASK[1:0]);
         if (step == tgst_pkg::TEST_STEPS) begin
            next_test_busy   = 1'b0;
            next_brightness  = 8'hFF;
            next_preset_show = 1'b1;
            next_preset_code = lowest_code;
            if (lowest_code == tgst_pkg::CODE_NONE) begin
               next_active_disp = tgst_pkg::TGST_DISP_DASH;
               next_fail_ind    = 1'b0;
            end else begin
               next_active_disp = tgst_pkg::TGST_DISP_FAIL;
               next_fail_ind    = 1'b1;
            end
         end
      end else begin
         next_step_cnt = step_cnt + 32'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_seen               <= 11'h000;
         step_cnt                 <= 32'h0;
         step                     <= 8'h00;
         test_busy                <= 1'b0;
         brightness               <= 8'hFF;
         active_disp              <= tgst_pkg::TGST_DISP_BLANK;
         self_test_fail_indicator <= 1'b0;
         preset_code              <= 8'h00;
         preset_show              <= 1'b0;
      end else begin
         fault_seen               <= next_fault_seen;
         step_cnt                 <= next_step_cnt;
         step                     <= next_step;
         test_busy                <= next_test_busy;
         brightness               <= next_brightness;
         active_disp              <= next_active_disp;
         self_test_fail_indicator <= next_fail_ind;
         preset_code              <= next_preset_code;
         preset_show              <= next_preset_show;
      end
   end

   // ----------------------------------------
   // audio
   // ----------------------------------------
   // warning beeps take priority; a tone asked while busy is dropped
   assign bif.start     = beep_start | tone_kick;
   assign bif.tone_test = tone_kick & ~beep_start;

   tgst_beeper #(
      .BEEP_CYC      (BEEP_CYC),
      .TONE_HALF_CYC (TONE_HALF_CYC)
   ) u_beeper (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .bif     (bif),
      .tone    (audio_tone)
   );
endmodule
`default_nettype wire

// ---- tgst_pkg.sv ----
// tgst_pkg: constants and types for the transmit guard and self-test block
// assumes a 200 MHz system clock; long counts are overridden by top parameters
package tgst_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned TX_LIMIT_S       = 120;
   localparam longint unsigned TX_LIMIT_CYC = longint'(TX_LIMIT_S) * CLK_MHZ * 1000000;
   localparam int unsigned DKEY_GAP_MS      = 300;
   localparam longint unsigned DKEY_GAP_CYC = longint'(DKEY_GAP_MS) * CLK_MHZ * 1000;
   localparam int unsigned TEMP_PERIOD_US   = 1000;
   localparam longint unsigned TEMP_PERIOD_CYC = longint'(TEMP_PERIOD_US) * CLK_MHZ;
   localparam int unsigned BEEP_MS          = 100;
   localparam longint unsigned BEEP_CYC     = longint'(BEEP_MS) * CLK_MHZ * 1000;
   localparam int unsigned TONE_HALF_US     = 500;
   localparam longint unsigned TONE_HALF_CYC = longint'(TONE_HALF_US) * CLK_MHZ;
   localparam int unsigned TEST_STEP_MS     = 20;
   localparam longint unsigned TEST_STEP_CYC = longint'(TEST_STEP_MS) * CLK_MHZ * 1000;
   // ----------------------------------------
   // temperature and test sequence
   // ----------------------------------------
   localparam logic [7:0] TEMP_LIMIT_C   = 8'hA0;
   localparam logic [7:0] TEST_STEPS     = 8'hFF;
   localparam logic [3:0] BEEP_COUNT     = 4'h4;
   localparam logic [3:0] TEST_TONE_MASK = 4'h3;
   // ----------------------------------------
   // fault inputs, index order lowest code first
   // ----------------------------------------
   localparam int unsigned NFAULT = 11;
   localparam logic [7:0] FAULT_BCD [NFAULT] = '{
      8'h14, 8'h15, 8'h16, 8'h17, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
   localparam logic [7:0] CODE_NONE  = 8'h00;
   localparam int unsigned IDX_TEMP    = 3;
   localparam int unsigned IDX_TIMEOUT = 10;
   typedef enum logic [1:0] {TGST_DISP_BLANK, TGST_DISP_DASH, TGST_DISP_FAIL} tgst_disp_t;
   typedef enum logic [2:0] {TGST_IDLE, TGST_TX, TGST_WAIT_REL, TGST_HOT_GAP,
                             TGST_HOT_TX} tgst_key_t;
endpackage

// ---- tgst_beep_if.sv ----
// tgst_beep_if: beep request and busy between key guard and beeper
// assumes both ends share sys_clk
`timescale 1ns/1ps
`default_nettype none
interface tgst_beep_if;
   logic start;
   logic tone_test;
   logic busy;
   modport ctrl (output start, output tone_test, input busy);
   modport gen  (input start, input tone_test, output busy);
endinterface
`default_nettype wire

// ---- tgst_beeper.sv ----
// tgst_beeper: square-wave tone burst generator
// assumes a single-cycle start; tone_test selects the longer self-test pattern
`timescale 1ns/1ps
`default_nettype none
module tgst_beeper #(
   parameter longint unsigned BEEP_CYC      = tgst_pkg::BEEP_CYC,
   parameter longint unsigned TONE_HALF_CYC = tgst_pkg::TONE_HALF_CYC
) (
   // clock and reset
   input  wire logic    sys_clk,
   input  wire logic    arst_n,
   // control
   tgst_beep_if.gen     bif,
   // audio
   output logic         tone
);
   logic [31:0] dur;
   logic [31:0] half;
   logic [3:0]  left;
   logic        next_tone;
   logic [31:0] next_dur;
   logic [31:0] next_half;
   logic [3:0]  next_left;

   always_comb begin
      next_tone = tone;
      next_dur  = dur;
      next_half = half;
      next_left = left;
      if (bif.start && left == 4'h0) begin
         // two beeps are two on-phases of four; test pattern runs eight phases
         next_left = bif.tone_test ? 4'h8 : tgst_pkg::BEEP_COUNT;
         next_dur  = 32'h0;
         next_half = 32'h0;
         next_tone = 1'b0;
      end else if (left != 4'h0) begin
         if (dur >= 32'(BEEP_CYC - 1)) begin
            next_dur  = 32'h0;
            next_left = left - 4'h1;
         end else begin
            next_dur = dur + 32'h1;
         end
         if (half >= 32'(TONE_HALF_CYC - 1)) begin
            next_half = 32'h0;
            next_tone = left[0] ? 1'b0 : ~tone;
         end else begin
            next_half = half + 32'h1;
         end
         if (next_left == 4'h0) begin
            next_tone = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tone <= 1'b0;
         dur  <= 32'h0;
         half <= 32'h0;
         left <= 4'h0;
      end else begin
         tone <= next_tone;
         dur  <= next_dur;
         half <= next_half;
         left <= next_left;
      end
   end

   assign bif.busy = (left != 4'h0);
endmodule
`default_nettype wire

// ---- tgst_top_asserts.sv ----
// tgst_top_asserts: port-level checks of the transmit guard and self-test
// assumes it is bound into tgst_top and given the same count parameters
`timescale 1ns/1ps
`default_nettype none
module tgst_top_asserts #(
   parameter longint unsigned TX_LIMIT_CYC  = 200,
   parameter longint unsigned TEST_STEP_CYC = 2
) (
   // clock and reset
   input wire logic                 sys_clk,
   input wire logic                 arst_n,
   // stimulus
   input wire logic                 ptt,
   input wire logic                 test_req,
   // watched outputs
   input wire logic                 tx_key,
   input wire logic                 rx_enable,
   input wire logic                 sidetone_en,
   input wire logic                 test_busy,
   input wire logic [7:0]           brightness,
   input wire tgst_pkg::tgst_disp_t active_disp,
   input wire logic                 self_test_fail_indicator,
   input wire logic [7:0]           preset_code,
   input wire logic                 preset_show
);
   // ----------------------------------------
   // run-length counters
   // ----------------------------------------
   // long counts exceed any repetition, so they are counted here
   longint unsigned tx_run;
   longint unsigned busy_run;
   longint unsigned next_tx_run;
   longint unsigned next_busy_run;
   always_comb begin
      next_tx_run = tx_key ? tx_run + 1 : 0;
      next_busy_run = test_busy ? busy_run + 1 : 0;
   end
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_run <= 0;
         busy_run <= 0;
      end else begin
         tx_run <= next_tx_run;
         busy_run <= next_busy_run;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   rx_inverse_a: assert property (rx_enable == !tx_key)
      else $error("receive enable not inverse of key");
   sidetone_key_a: assert property (sidetone_en == tx_key)
      else $error("sidetone differs from key");
   key_needs_ptt_a: assert property (tx_key |-> $past(ptt))
      else $error("keyed without push-to-talk");
   release_drop_a: assert property ($fell(ptt) && tx_key |=> !tx_key)
      else $error("key held after release");
   key_limit_a: assert property (tx_run <= TX_LIMIT_CYC + 1)
      else $error("key held past limit");
   test_start_a: assert property (test_req && !test_busy |=> test_busy && !preset_show)
      else $error("test request not taken");
   idle_bright_a: assert property (!test_busy |-> brightness == 8'hFF)
      else $error("idle brightness not full");
   sweep_start_a: assert property ($rose(test_busy) |-> brightness == 8'h00)
      else $error("sweep does not start at minimum");
   test_len_a: assert property (busy_run <= 256 * TEST_STEP_CYC + 2)
      else $error("self-test runs too long");
   pass_show_a: assert property ($fell(test_busy) |->
      preset_show && ((preset_code == 8'h00) == !self_test_fail_indicator))
      else $error("result code and indicator disagree");
   fail_disp_a: assert property (preset_show |->
      self_test_fail_indicator == (active_disp == tgst_pkg::TGST_DISP_FAIL))
      else $error("fail display disagrees with indicator");
   hidden_a: assert property (!preset_show |-> active_disp == tgst_pkg::TGST_DISP_BLANK)
      else $error("result shown before test");
   key_cov: cover property ($rose(tx_key));
   cutoff_cov: cover property ($fell(tx_key) && ptt);
   fail_cov: cover property ($fell(test_busy) ##1 self_test_fail_indicator);
endmodule
`default_nettype wire

// ---- tgst_ptt_model.sv ----
// tgst_ptt_model: push-to-talk switch and control unit test switch
// assumes tasks are called just after a rising sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module tgst_ptt_model (
   // clock
   input  wire logic sys_clk,
   // operator side
   output var logic  ptt,
   output var logic  test_req
);
   initial begin
      ptt = 1'b0;
      test_req = 1'b0;
   end
   task automatic set_ptt(input logic v);
      ptt = v;
   endtask
   task automatic pulse_test();
      test_req = 1'b1;
      @(posedge sys_clk);
      #1;
      test_req = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- tgst_top_bench.sv ----
// tgst_top_bench: self-checking bench for tgst_top
// assumes the package, beep interface, beeper, model and checker are compiled
`timescale 1ns/1ps
`default_nettype none
module tgst_top_bench;
   // ----------------------------------------
   // setup
   // ----------------------------------------
   localparam longint unsigned TXL = 200;
   localparam longint unsigned GAP = 50;
   localparam longint unsigned TPER = 4;
   logic                 sys_clk;
   logic                 arst_n;
   logic                 ptt;
   logic                 test_req;
   logic [7:0]           tx_temp_c;
   logic [10:0]          fault_in;
   logic                 tx_key;
   logic                 rx_enable;
   logic                 sidetone_en;
   logic                 audio_tone;
   logic                 test_busy;
   logic [7:0]           brightness;
   tgst_pkg::tgst_disp_t active_disp;
   logic                 fail_ind;
   logic [7:0]           preset_code;
   logic                 preset_show;
   int                   err_count = 0;
   int                   samples_checked = 0;
   int                   cycles = 0;
   tgst_top #(.TX_LIMIT_CYC(TXL), .DKEY_GAP_CYC(GAP), .TEMP_PERIOD_CYC(TPER),
      .BEEP_CYC(10), .TEST_STEP_CYC(2), .TONE_HALF_CYC(2)) i_tgst_top (
      .sys_clk(sys_clk), .arst_n(arst_n), .ptt(ptt), .test_req(test_req),
      .tx_temp_c(tx_temp_c), .fault_in(fault_in), .tx_key(tx_key),
      .rx_enable(rx_enable), .sidetone_en(sidetone_en), .audio_tone(audio_tone),
      .test_busy(test_busy), .brightness(brightness), .active_disp(active_disp),
      .self_test_fail_indicator(fail_ind), .preset_code(preset_code),
      .preset_show(preset_show));
   tgst_ptt_model i_tgst_ptt_model (.sys_clk(sys_clk), .ptt(ptt), .test_req(test_req));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // a hang cuts the run short and counts as a mismatch
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         $display("mismatch at %0t: run timed out", $time);
         conclude();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // audio tone seen high within n cycles
   task automatic listen(input int n, output logic heard);
      heard = 1'b0;
      repeat (n) begin
         step(1);
         if (audio_tone === 1'b1) begin
            heard = 1'b1;
         end
      end
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic run_test(input logic [7:0] code, input logic fail);
      int n;
      logic [7:0] top;
      logic heard;
      i_tgst_ptt_model.pulse_test();
      chk(8'(test_busy), 8'h01);
      chk(8'(preset_show), 8'h00);
      chk(brightness, 8'h00);
      top = 8'h00;
      heard = 1'b0;
      n = 0;
      while (test_busy === 1'b1 && n < 700) begin
         if (brightness > top) begin
            top = brightness;
         end
         if (audio_tone === 1'b1) begin
            heard = 1'b1;
         end
         step(1);
         n++;
      end
      chk(top, 8'hF0);
      chk(8'(heard), 8'h01);
      chk(8'(preset_show), 8'h01);
      chk(preset_code, code);
      chk(8'(fail_ind), 8'(fail));
      chk(8'(active_disp), fail ? 8'(tgst_pkg::TGST_DISP_FAIL) : 8'(tgst_pkg::TGST_DISP_DASH));
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk(8'(tx_key), 8'h00);
      chk(8'(rx_enable), 8'h01);
      chk(brightness, 8'hFF);
      chk(8'(preset_show), 8'h00);
      chk(8'(active_disp), 8'(tgst_pkg::TGST_DISP_BLANK));
   endtask
   // faults are sticky, so codes are added from the highest down
   task automatic t_tests();
      run_test(8'h00, 1'b0);
      for (int i = 10; i >= 0; i--) begin
         fault_in[i] = 1'b1;
         step(1);
         run_test(tgst_pkg::FAULT_BCD[i], 1'b1);
      end
   endtask
   task automatic t_key();
      // just below the limit still transmits
      tx_temp_c = 8'h9F;
      i_tgst_ptt_model.set_ptt(1'b1);
      step(2);
      chk(8'(tx_key), 8'h01);
      chk(8'(rx_enable), 8'h00);
      chk(8'(sidetone_en), 8'h01);
      step(20);
      i_tgst_ptt_model.set_ptt(1'b0);
      step(2);
      chk(8'(tx_key), 8'h00);
      chk(8'(rx_enable), 8'h01);
   endtask
   task automatic t_timeout();
      logic heard;
      i_tgst_ptt_model.set_ptt(1'b1);
      step(int'(TXL) - 10);
      chk(8'(tx_key), 8'h01);
      step(20);
      chk(8'(tx_key), 8'h00);
      listen(10, heard);
      chk(8'(heard), 8'h00);
      i_tgst_ptt_model.set_ptt(1'b0);
      listen(20, heard);
      chk(8'(heard), 8'h01);
      step(40);
      chk(8'(audio_tone), 8'h00);
      i_tgst_ptt_model.set_ptt(1'b1);
      step(150);
      i_tgst_ptt_model.set_ptt(1'b0);
      step(3);
      i_tgst_ptt_model.set_ptt(1'b1);
      step(150);
      chk(8'(tx_key), 8'h01);
      i_tgst_ptt_model.set_ptt(1'b0);
      step(60);
   endtask
   task automatic t_hot();
      logic heard;
      i_tgst_ptt_model.set_ptt(1'b1);
      step(10);
      tx_temp_c = 8'hA0;
      step(12);
      chk(8'(tx_key), 8'h01);
      tx_temp_c = 8'hA1;
      step(int'(TPER) + 3);
      chk(8'(tx_key), 8'h00);
      chk(8'(sidetone_en), 8'h00);
      listen(8, heard);
      chk(8'(heard), 8'h00);
      i_tgst_ptt_model.set_ptt(1'b0);
      listen(20, heard);
      chk(8'(heard), 8'h01);
      step(40);
      i_tgst_ptt_model.set_ptt(1'b1);
      step(int'(GAP) + 10);
      chk(8'(tx_key), 8'h00);
      i_tgst_ptt_model.set_ptt(1'b0);
      step(60);
      i_tgst_ptt_model.set_ptt(1'b1);
      step(3);
      i_tgst_ptt_model.set_ptt(1'b0);
      step(3);
      i_tgst_ptt_model.set_ptt(1'b1);
      step(5);
      chk(8'(tx_key), 8'h01);
      tx_temp_c = 8'hFE;
      step(40);
      chk(8'(tx_key), 8'h01);
      i_tgst_ptt_model.set_ptt(1'b0);
      step(2);
      chk(8'(tx_key), 8'h00);
      tx_temp_c = 8'h20;
   endtask
   initial begin
      arst_n = 1'b0;
      tx_temp_c = 8'h20;
      fault_in = '0;
      step(12);
      arst_n = 1'b1;
      t_reset();
      t_tests();
      // a second reset clears the sticky fault record
      fault_in = '0;
      arst_n = 1'b0;
      step(3);
      arst_n = 1'b1;
      t_reset();
      t_key();
      t_timeout();
      run_test(8'h27, 1'b1);
      t_hot();
      run_test(8'h17, 1'b1);
      conclude();
   end
endmodule
bind tgst_top tgst_top_asserts #(.TX_LIMIT_CYC(TX_LIMIT_CYC), .TEST_STEP_CYC(TEST_STEP_CYC))
   i_tgst_top_asserts (.sys_clk(sys_clk), .arst_n(arst_n), .ptt(ptt),
   .test_req(test_req), .tx_key(tx_key), .rx_enable(rx_enable),
   .sidetone_en(sidetone_en), .test_busy(test_busy), .brightness(brightness),
   .active_disp(active_disp), .self_test_fail_indicator(self_test_fail_indicator),
   .preset_code(preset_code), .preset_show(preset_show));
`default_nettype wire
